/* core/adcc_top.sv */
`default_nettype none

module adcc_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Source clocks arrive as one-cycle enables from same-clock dividers.
  input wire logic i_peripheral_clock_tick,
  input wire logic i_system_oscillator_clock_tick,
  input wire logic i_auxiliary_loop_divided_clock_tick,
  input wire logic i_loop_quarter_clock_tick,
  input wire logic i_core0_start,
  input wire logic i_core1_start,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [31:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_common_source_tick,
  output logic o_shared_core_on,
  output logic [1:0] o_dedicated_core_on,
  output logic [1:0] o_core_conversion_clock,
  output logic [1:0] o_core_busy,
  output logic [1:0] o_early_irq,
  output logic [1:0] o_core_ready
);

  logic [15:0] clk_en_r;
  logic [15:0] clk_en_nxt;
  logic [15:0] core_ctl_r [2];
  logic [15:0] core_ctl_nxt [2];
  logic [1:0] early_flag_r;
  logic [1:0] early_flag_nxt;
  logic [1:0] ready_flag_r;
  logic [1:0] ready_flag_nxt;
  logic aw_held_r;
  logic aw_held_nxt;
  logic [31:0] awaddr_r;
  logic [31:0] awaddr_nxt;
  logic w_held_r;
  logic w_held_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic [3:0] wstrb_r;
  logic [3:0] wstrb_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic wr_go;
  logic rd_go;
  logic [15:0] wr_bytes;
  logic [15:0] lane_mask;
  logic [15:0] status_view;
  logic [1:0] clock_select;
  logic [5:0] common_div;
  logic module_tick;
  logic common_tick;
  logic [1:0] core_on;
  logic [1:0] core_start;
  logic [1:0] core_busy;
  logic [1:0] core_early;
  logic [1:0] core_ready;

  // Protection attributes are accepted and not checked.
  logic unused_prot;
  assign unused_prot = ^{i_awprot, i_arprot};

  // Field views of the clock and core enable register.
  assign clock_select = clk_en_r[adcc_pkg::CLK_SEL_LSB +: 2];
  assign common_div = clk_en_r[adcc_pkg::CLK_DIV_LSB +: 6];
  assign core_on[0] = clk_en_r[adcc_pkg::CORE0_ON_BIT];
  assign core_on[1] = clk_en_r[adcc_pkg::CORE1_ON_BIT];
  assign core_start = {i_core1_start, i_core0_start};

  // Module clock source selection.
  always_comb begin
    case (clock_select)
      adcc_pkg::SRC_LOOP_QUARTER: module_tick = i_loop_quarter_clock_tick;
      adcc_pkg::SRC_AUX_LOOP: module_tick = i_auxiliary_loop_divided_clock_tick;
      adcc_pkg::SRC_SYS_OSC: module_tick = i_system_oscillator_clock_tick;
      default: module_tick = i_peripheral_clock_tick;
    endcase
  end

  // Common source clock: one tick every divider value plus one module ticks.
  adcc_tick_div u_common_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_clear(1'b0),
    .i_tick(module_tick),
    .i_last({1'b0, common_div}),
    .o_pulse(common_tick)
  );

  // Each dedicated core runs from its own control register copy.
  for (genvar gi = 0; gi < 2; gi++) begin : g_core
    adcc_core u_core (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_src_tick(common_tick),
      .i_on(core_on[gi]),
      .i_early_irq_lead_select(core_ctl_r[gi][adcc_pkg::LEAD_LSB +: 3]),
      .i_bit_depth_select(core_ctl_r[gi][adcc_pkg::DEPTH_LSB +: 2]),
      .i_core_clock_divisor(core_ctl_r[gi][adcc_pkg::DIVISOR_LSB +: 7]),
      .i_start(core_start[gi]),
      .o_core_conversion_clock(o_core_conversion_clock[gi]),
      .o_busy(core_busy[gi]),
      .o_early(core_early[gi]),
      .o_ready(core_ready[gi])
    );
  end

  // Bus handshakes: each address or data beat is held until the write is done.
  assign o_awready = !aw_held_r;
  assign o_wready = !w_held_r;
  assign o_arready = !rvalid_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign rd_go = i_arvalid && !rvalid_r;

  // Byte strobes become a 16-bit lane mask over the low half-word.
  assign lane_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wr_bytes = wdata_r[15:0];

  // Live status word seen by reads.
  always_comb begin
    status_view = 16'h0000;
    status_view[adcc_pkg::ST_EARLY_LSB +: 2] = early_flag_r;
    status_view[adcc_pkg::ST_READY_LSB +: 2] = ready_flag_r;
    status_view[adcc_pkg::ST_BUSY_LSB +: 2] = core_busy;
  end

  // Write channel capture and response.
  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt = awaddr_r;
    w_held_nxt = w_held_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (bvalid_r && i_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (i_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = i_awaddr;
    end
    if (i_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = i_wdata;
      wstrb_nxt = i_wstrb;
    end
    if (wr_go) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      if (awaddr_r == adcc_pkg::ADDR_CLK_EN || awaddr_r == adcc_pkg::ADDR_CORE0 ||
          awaddr_r == adcc_pkg::ADDR_CORE1 || awaddr_r == adcc_pkg::ADDR_STATUS) begin
        bresp_nxt = adcc_pkg::RESP_OKAY;
      end else begin
        bresp_nxt = adcc_pkg::RESP_SLVERR;
      end
    end
  end

  // Configuration registers and sticky flags; hardware set wins over clear.
  always_comb begin
    logic [15:0] clr;
    logic [15:0] wmask;
    clr = 16'h0000;
    wmask = 16'h0000;
    clk_en_nxt = clk_en_r;
    core_ctl_nxt[0] = core_ctl_r[0];
    core_ctl_nxt[1] = core_ctl_r[1];
    if (wr_go) begin
      if (awaddr_r == adcc_pkg::ADDR_CLK_EN) begin
        wmask = lane_mask & adcc_pkg::CLK_EN_WMASK;
        clk_en_nxt = (clk_en_r & ~wmask) | (wr_bytes & wmask);
      end else if (awaddr_r == adcc_pkg::ADDR_CORE0) begin
        wmask = lane_mask & adcc_pkg::CORE_WMASK;
        core_ctl_nxt[0] = (core_ctl_r[0] & ~wmask) | (wr_bytes & wmask);
      end else if (awaddr_r == adcc_pkg::ADDR_CORE1) begin
        wmask = lane_mask & adcc_pkg::CORE_WMASK;
        core_ctl_nxt[1] = (core_ctl_r[1] & ~wmask) | (wr_bytes & wmask);
      end else if (awaddr_r == adcc_pkg::ADDR_STATUS) begin
        clr = wr_bytes & lane_mask & adcc_pkg::STATUS_W1C_MASK;
      end
    end
    early_flag_nxt = (early_flag_r & ~clr[adcc_pkg::ST_EARLY_LSB +: 2]) | core_early;
    ready_flag_nxt = (ready_flag_r & ~clr[adcc_pkg::ST_READY_LSB +: 2]) | core_ready;
  end

  // Read channel: data registered one cycle after the address is taken.
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && i_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = adcc_pkg::RESP_OKAY;
      if (i_araddr == adcc_pkg::ADDR_CLK_EN) begin
        rdata_nxt = {16'h0000, clk_en_r};
      end else if (i_araddr == adcc_pkg::ADDR_CORE0) begin
        rdata_nxt = {16'h0000, core_ctl_r[0]};
      end else if (i_araddr == adcc_pkg::ADDR_CORE1) begin
        rdata_nxt = {16'h0000, core_ctl_r[1]};
      end else if (i_araddr == adcc_pkg::ADDR_STATUS) begin
        rdata_nxt = {16'h0000, status_view};
      end else begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = adcc_pkg::RESP_SLVERR;
      end
    end
  end

  // Bus state registers.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else begin
      aw_held_r <= aw_held_nxt;
      awaddr_r <= awaddr_nxt;
      w_held_r <= w_held_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Configuration and flag registers.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      clk_en_r <= adcc_pkg::CLK_EN_RESET;
      core_ctl_r[0] <= adcc_pkg::CORE_RESET;
      core_ctl_r[1] <= adcc_pkg::CORE_RESET;
      early_flag_r <= 2'h0;
      ready_flag_r <= 2'h0;
    end else begin
      clk_en_r <= clk_en_nxt;
      core_ctl_r[0] <= core_ctl_nxt[0];
      core_ctl_r[1] <= core_ctl_nxt[1];
      early_flag_r <= early_flag_nxt;
      ready_flag_r <= ready_flag_nxt;
    end
  end

  // Outputs.
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_common_source_tick = common_tick;
  assign o_shared_core_on = clk_en_r[adcc_pkg::SHARED_ON_BIT];
  assign o_dedicated_core_on = core_on;
  assign o_core_busy = core_busy;
  assign o_early_irq = core_early;
  assign o_core_ready = core_ready;

endmodule // adcc_top

`default_nettype wire

/* core/adcc_pkg.sv */
`default_nettype none

package adcc_pkg;

  // Register byte addresses on the 32-bit register bus.
  localparam logic [31:0] ADDR_CLK_EN = 32'h0000_0000;
  localparam logic [31:0] ADDR_CORE0 = 32'h0000_0004;
  localparam logic [31:0] ADDR_CORE1 = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000c;

  // Field positions of the clock and core enable register.
  localparam int CLK_SEL_LSB = 14;
  localparam int CLK_DIV_LSB = 8;
  localparam int SHARED_ON_BIT = 7;
  localparam int CORE1_ON_BIT = 1;
  localparam int CORE0_ON_BIT = 0;

  // Field positions of the dedicated core control register.
  localparam int LEAD_LSB = 10;
  localparam int DEPTH_LSB = 8;
  localparam int DIVISOR_LSB = 0;

  // Status register layout: sticky early and ready flags, then busy levels.
  localparam int ST_EARLY_LSB = 0;
  localparam int ST_READY_LSB = 2;
  localparam int ST_BUSY_LSB = 4;
  localparam logic [15:0] STATUS_W1C_MASK = 16'h000f;

  // Reset values and writable bit masks.
  localparam logic [15:0] CLK_EN_RESET = 16'h0000;
  localparam logic [15:0] CORE_RESET = 16'h0000;
  localparam logic [15:0] CLK_EN_WMASK = 16'hff83;
  localparam logic [15:0] CORE_WMASK = 16'h1f7f;

  // Module clock source codes.
  localparam logic [1:0] SRC_PERIPHERAL = 2'h0;
  localparam logic [1:0] SRC_SYS_OSC = 2'h1;
  localparam logic [1:0] SRC_AUX_LOOP = 2'h2;
  localparam logic [1:0] SRC_LOOP_QUARTER = 2'h3;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Core clocks spent on a conversion beyond the bit depth (sampling overhead).
  localparam logic [3:0] CONV_OVERHEAD = 4'h2;

  // Lead in core clocks: code plus one, with codes 0 and 1 both giving one.
  function automatic logic [3:0] lead_of(input logic [2:0] code);
    lead_of = (code <= 3'h1) ? 4'h1 : ({1'b0, code} + 4'h1);
  endfunction

  // Conversion length in core clocks for a bit depth code.
  function automatic logic [3:0] conv_len(input logic [1:0] depth);
    logic [3:0] bits;
    bits = 4'h6 + {1'b0, depth, 1'b0};
    conv_len = bits + CONV_OVERHEAD;
  endfunction

endpackage

`default_nettype wire

/* core/adcc_tick_div.sv */
`default_nettype none

// Counts enable ticks and fires once every i_last plus one ticks.
module adcc_tick_div (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic [6:0] i_last,
  output logic o_pulse
);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;

  // Terminal count reached on a tick; a shrunk limit ends the period at once.
  assign o_pulse = i_tick && !i_clear && (cnt_r >= i_last);

  // Next count.
  always_comb begin
    cnt_nxt = cnt_r;
    if (i_clear) begin
      cnt_nxt = 7'h00;
    end else if (o_pulse) begin
      cnt_nxt = 7'h00;
    end else if (i_tick) begin
      cnt_nxt = cnt_r + 7'h01;
    end
  end

  // Count register.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // adcc_tick_div

`default_nettype wire

/* core/adcc_core.sv */
`default_nettype none

// One dedicated converter core: own clock divider and conversion sequencer.
module adcc_core (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_src_tick,
  input wire logic i_on,
  input wire logic [2:0] i_early_irq_lead_select,
  input wire logic [1:0] i_bit_depth_select,
  input wire logic [6:0] i_core_clock_divisor,
  input wire logic i_start,
  output logic o_core_conversion_clock,
  output logic o_busy,
  output logic o_early,
  output logic o_ready
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } adcc_core_st_t;

  adcc_core_st_t st_r;
  adcc_core_st_t st_nxt;
  logic core_clk_r;
  logic core_clk_nxt;
  logic [3:0] remain_r;
  logic [3:0] remain_nxt;
  logic [3:0] lead_r;
  logic [3:0] lead_nxt;
  logic early_r;
  logic early_nxt;
  logic ready_r;
  logic ready_nxt;
  logic [6:0] half_last;
  logic half_pulse;
  logic core_tick;
  logic [3:0] remain_dec;

  // Half period of the core clock is the divisor, 0 and 1 both meaning one.
  assign half_last = (i_core_clock_divisor <= 7'h01) ? 7'h00 : (i_core_clock_divisor - 7'h01);

  adcc_tick_div u_half_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_clear(!i_on),
    .i_tick(i_src_tick),
    .i_last(half_last),
    .o_pulse(half_pulse)
  );

  // A core clock period is two half periods; the rising edge advances work.
  assign core_tick = half_pulse && !core_clk_r;
  assign remain_dec = remain_r - 4'h1;

  // Sequencer: count core clocks down to ready, flag the lead point.
  always_comb begin
    st_nxt = st_r;
    core_clk_nxt = i_on ? (core_clk_r ^ half_pulse) : 1'b0;
    remain_nxt = remain_r;
    lead_nxt = lead_r;
    early_nxt = 1'b0;
    ready_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (i_start && i_on) begin
          st_nxt = ST_CONV;
          remain_nxt = adcc_pkg::conv_len(i_bit_depth_select);
          lead_nxt = adcc_pkg::lead_of(i_early_irq_lead_select);
        end
      end
      ST_CONV: begin
        if (!i_on) begin
          st_nxt = ST_IDLE;
        end else if (core_tick) begin
          remain_nxt = remain_dec;
          early_nxt = (remain_dec == lead_r);
          if (remain_dec == 4'h0) begin
            ready_nxt = 1'b1;
            st_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
      core_clk_r <= 1'b0;
      remain_r <= 4'h0;
      lead_r <= 4'h1;
      early_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      core_clk_r <= core_clk_nxt;
      remain_r <= remain_nxt;
      lead_r <= lead_nxt;
      early_r <= early_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign o_core_conversion_clock = core_clk_r;
  assign o_busy = (st_r == ST_CONV);
  assign o_early = early_r;
  assign o_ready = ready_r;

endmodule // adcc_core

`default_nettype wire

/* verif/adcc_checker.sv */
`default_nettype none

// Watches the register bus and the core outputs of the converter clock block.
module adcc_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_awaddr,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic i_peripheral_clock_tick,
  input wire logic i_system_oscillator_clock_tick,
  input wire logic i_auxiliary_loop_divided_clock_tick,
  input wire logic i_loop_quarter_clock_tick,
  input wire logic o_common_source_tick,
  input wire logic o_shared_core_on,
  input wire logic [1:0] o_dedicated_core_on,
  input wire logic [1:0] o_core_conversion_clock,
  input wire logic [1:0] o_core_busy,
  input wire logic [1:0] o_early_irq,
  input wire logic [1:0] o_core_ready
);
  logic wr_both;
  logic wr_clk;
  logic rd_core;

  // Address and data taken together, the case that hits the enable register, and reads of the core registers.
  assign wr_both = i_awvalid && o_awready && i_wvalid && o_wready;
  assign wr_clk = wr_both && i_awaddr == adcc_pkg::ADDR_CLK_EN && i_wstrb[0];
  assign rd_core = i_arvalid && o_arready &&
    (i_araddr == adcc_pkg::ADDR_CORE0 || i_araddr == adcc_pkg::ADDR_CORE1);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_shared_on_follows: assert property (
    wr_clk |-> ##2 o_shared_core_on == $past(i_wdata[7], 2)) else $error("shared enable wrong");
  a_core_on_follows: assert property (
    wr_clk |-> ##2 o_dedicated_core_on == $past(i_wdata[1:0], 2))
    else $error("core enable wrong");
  a_write_answer: assert property (
    wr_both && !o_bvalid |-> ##2 o_bvalid) else $error("write answer late");
  a_core_read_zero: assert property (
    rd_core |=> o_rvalid && o_rdata[31:13] == 19'h0 && !o_rdata[7]) else $error("bits not zero");
  a_tick_source: assert property (
    o_common_source_tick |-> (i_peripheral_clock_tick || i_system_oscillator_clock_tick ||
    i_auxiliary_loop_divided_clock_tick || i_loop_quarter_clock_tick)) else $error("stray tick");
  a_clock_off_idle: assert property (
    !o_dedicated_core_on[0] && $past(!o_dedicated_core_on[0]) |-> !o_core_conversion_clock[0])
    else $error("core clock runs while off");
  a_abort_idle: assert property (
    $fell(o_dedicated_core_on[0]) |-> ##[0:2] !o_core_busy[0]) else $error("abort failed");
  a_ready_after_busy: assert property (
    o_core_ready[1] |-> $past(o_core_busy[1])) else $error("ready without conversion");
  a_early_in_busy: assert property (
    o_early_irq[0] |-> $past(o_core_busy[0]) && !o_core_ready[0]) else $error("early misplaced");
  a_core_clock_tick: assert property (
    $rose(o_core_conversion_clock[0]) |-> $past(o_common_source_tick))
    else $error("core clock rose without tick");
endmodule // adcc_checker

bind adcc_top adcc_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
  .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid),
  .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
  .o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_peripheral_clock_tick(i_peripheral_clock_tick),
  .i_system_oscillator_clock_tick(i_system_oscillator_clock_tick),
  .i_auxiliary_loop_divided_clock_tick(i_auxiliary_loop_divided_clock_tick),
  .i_loop_quarter_clock_tick(i_loop_quarter_clock_tick),
  .o_common_source_tick(o_common_source_tick), .o_shared_core_on(o_shared_core_on),
  .o_dedicated_core_on(o_dedicated_core_on), .o_core_conversion_clock(o_core_conversion_clock),
  .o_core_busy(o_core_busy), .o_early_irq(o_early_irq), .o_core_ready(o_core_ready));

`default_nettype wire

/* verif/testbench.sv */
`default_nettype none

// Drives the converter clock block over its register bus and checks it against a model.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic full = 1'b0;
  logic [3:0] tk = 4'h0;
  logic [1:0] st = 2'h0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rd;
  logic awr, wr_rdy, bv, arr, rv, cst, shr;
  logic [1:0] br, rr, don, cclk, busy, eirq, crdy;
  logic [31:0] adr [3] = '{adcc_pkg::ADDR_CLK_EN, adcc_pkg::ADDR_CORE0, adcc_pkg::ADDR_CORE1};
  logic [15:0] wmask [3] = '{16'hff83, 16'h1f7f, 16'h1f7f};
  int mirror [3] = '{0, 0, 0};
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;

  adcc_top uut (.i_clk_sys(clk), .i_rst(rst), .i_peripheral_clock_tick(tk[0]),
    .i_system_oscillator_clock_tick(tk[1]), .i_auxiliary_loop_divided_clock_tick(tk[2]),
    .i_loop_quarter_clock_tick(tk[3]), .i_core0_start(st[0]), .i_core1_start(st[1]),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_awprot(3'h0), .i_wvalid(wv),
    .o_wready(wr_rdy), .i_wdata(wd), .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bre),
    .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .i_arprot(3'h0),
    .o_rvalid(rv), .i_rready(rre), .o_rdata(rd), .o_rresp(rr), .o_common_source_tick(cst),
    .o_shared_core_on(shr), .o_dedicated_core_on(don), .o_core_conversion_clock(cclk),
    .o_core_busy(busy), .o_early_irq(eirq), .o_core_ready(crdy));

  // Free-running system clock at 40 MHz.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Source enables are random pulses, or all high while conversions are timed.
  always @(posedge clk) begin
    tk <= full ? 4'hf : 4'($urandom);
  end

  // Cycle counter; a hang is cut short and reported.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end

  // Compares one result with its expected value.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // Bus write: address and data offered together, each released once taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, dd;
    ad = 0;
    dd = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awr) begin
        ad = 1;
        awv <= 1'b0;
      end
      if (!dd && wr_rdy) begin
        dd = 1;
        wv <= 1'b0;
      end
    end
    bre <= 1'b1;
    do @(posedge clk); while (!bv);
    r = br;
    bre <= 1'b0;
  endtask

  // Bus read: address held until taken, then ready held until the data arrives.
  task automatic rdr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    rre <= 1'b1;
    do @(posedge clk); while (!rv);
    d = rd;
    r = rr;
    rre <= 1'b0;
  endtask

  // Reads the clock enable and both core control registers back and compares them with the mirror.
  task automatic chk_all();
    logic [31:0] d;
    logic [1:0] r;
    for (int a = 0; a < 3; a++) begin
      rdr(adr[a], d, r);
      chk("read response", 32'(adcc_pkg::RESP_OKAY), 32'(r));
      chk("register", mirror[a], d);
    end
  endtask

  // Runs one conversion and times core clock, early pulse and ready pulse.
  task automatic conv(input int c, input int dp, input int cd, input int dv);
    int len, lead, per, ne, te, tl;
    logic pc;
    logic pb;
    logic [1:0] r;
    len = 6 + 2 * dp + 2;
    lead = (cd < 2) ? 1 : cd + 1;
    per = 2 * ((dv < 2) ? 1 : dv);
    ne = 0;
    te = -1000000;
    tl = 0;
    wr(adr[c + 1], (cd << 10) | (dp << 8) | dv, r);
    pc = cclk[c];
    pb = 1'b0;
    st[c] <= 1'b1;
    @(posedge clk);
    st[c] <= 1'b0;
    repeat (4000) begin
      @(posedge clk);
      if (cclk[c] && !pc && pb) begin
        if (ne > 0) chk("core period", per, cyc - tl);
        ne++;
        tl = cyc;
      end
      pc = cclk[c];
      pb = busy[c];
      if (eirq[c]) te = cyc;
      if (crdy[c]) break;
    end
    chk("core clocks", len, ne);
    chk("early lead", lead * per, cyc - te);
  endtask

  // Verdict and end of run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int gap;
    bit seen;
    int dvs [3] = '{0, 5, 63};
    void'($urandom(32'hcadf));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_all();
    rdr(32'h10, d, r);
    chk("unmapped read", 32'(adcc_pkg::RESP_SLVERR), 32'(r));
    chk("unmapped data", 0, d);
    wr(32'h10, 32'hffff, r);
    chk("unmapped write", 32'(adcc_pkg::RESP_SLVERR), 32'(r));
    for (int k = 0; k < 6; k++) begin
      d = $urandom;
      wr(adr[k % 3], d, r);
      mirror[k % 3] = d[15:0] & wmask[k % 3];
      chk("shared on", mirror[0] >> 7 & 1, 32'(shr));
      chk("cores on", mirror[0] & 3, 32'(don));
      chk_all();
    end
    for (int s = 0; s < 4; s++) begin
      foreach (dvs[i]) begin
        wr(adr[0], (s << 14) | (dvs[i] << 8), r);
        gap = 0;
        seen = 0;
        repeat (700) begin
          @(posedge clk);
          if (tk[s]) gap++;
          if (cst) begin
            chk("selected source", 1, 32'(tk[s]));
            if (seen) chk("common period", dvs[i] + 1, gap);
            gap = 0;
            seen = 1;
          end
        end
      end
    end
    full <= 1'b1;
    wr(adr[0], 32'h0083, r);
    for (int dp = 0; dp < 4; dp++) begin
      for (int cd = 0; cd < 8; cd++) begin
        if (!(dp == 0 && cd > 3) && !(dp == 1 && cd > 5)) conv(cd % 2, dp, cd, 1 + cd % 3);
      end
    end
    conv(0, 3, 2, 0);
    conv(1, 3, 2, 2);
    conv(0, 0, 3, 127);
    conv(1, 2, 4, $urandom % 128);
    wr(adr[1], 32'h0314, r);
    st[0] <= 1'b1;
    @(posedge clk);
    st[0] <= 1'b0;
    repeat (30) @(posedge clk);
    wr(adr[0], 32'h0002, r);
    repeat (4) @(posedge clk);
    chk("busy after abort", 0, 32'(busy[0]));
    chk("other core on", 2, 32'(don));
    seen = 0;
    repeat (600) begin
      @(posedge clk);
      if (crdy[0]) seen = 1;
    end
    chk("ready after abort", 0, 32'(seen));
    chk("core clock off", 0, 32'(cclk[0]));
    conclude();
  end
endmodule // testbench

`default_nettype wire
